/* test/iep_chk.sv */
`timescale 1ns/1ps
module iep_chk
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IEP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins, requests and core
  input wire logic ext_line_zero_pin,
  input wire logic ext_line_one_pin,
  input wire logic ext_line_two_pin,
  input iep_periph_req_t periph_req,
  input wire logic irq_ack,
  input wire logic irq_ret,
  input iep_vec_t irq_vec,
  input wire logic stop_wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // Register images
  // --------------------------------------------------------------
  // Images lag one cycle so they line up with the registered outputs
  logic [7:0] sh [256];
  logic [10:0] ena_q, hi_q, lo_q;
  logic arm_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        sh[i] <= 8'h00;
      end
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      sh[paddr[9:2]] <= pwdata[7:0];
    end
  end
  always_ff @(posedge clk) begin
    ena_q <= {sh[8'ha9][4:0], sh[8'ha8][5:0]} & {11{sh[8'ha8][7]}};
    hi_q <= {sh[8'hbb][4:0], sh[8'hb9][5:0]};
    lo_q <= {sh[8'hba][4:0], sh[8'hb8][5:0]};
    arm_q <= sh[8'ha8][0] | sh[8'ha8][2] | sh[8'ha9][2];
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  a_ready_wait:
    assert property (s_setup |-> !pready ##1 pready)
    else $error("pready late or early");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_quiet:
    assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response with data");
  a_read_upper:
    assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_vec_gated:
    assert property (irq_vec.valid |-> ena_q[irq_vec.id])
    else $error("vector from gated source");
  a_vec_level:
    assert property (irq_vec.valid |->
      irq_vec.level == {hi_q[irq_vec.id], lo_q[irq_vec.id]})
    else $error("vector level wrong");
  a_ack_clears:
    assert property (irq_ack && irq_vec.valid |=> !irq_vec.valid)
    else $error("vector stands after ack");
  a_wake_armed:
    assert property (stop_wake |-> arm_q)
    else $error("wake without armed pin");
endmodule

/* test/iep_core_model.sv */
`timescale 1ns/1ps
module iep_core_model
  import iep_pkg::*;
#(
  parameter int HOLD = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Vector handshake
  input iep_vec_t irq_vec,
  input wire logic ack_en,
  output logic irq_ack,
  output logic irq_ret,
  // Last vector taken
  output logic [3:0] got_id,
  output logic [1:0] got_lvl
);
  int depth;
  int tmr;
  // Handlers return in nesting order, each after HOLD quiet cycles
  always_ff @(posedge clk) begin
    irq_ret <= 1'b0;
    if (rst) begin
      irq_ack <= 1'b0;
      depth <= 0;
      tmr <= 0;
      got_id <= 4'h0;
      got_lvl <= 2'h0;
    end else begin
      irq_ack <= ack_en && irq_vec.valid && !irq_ack;
      if (irq_ack && irq_vec.valid) begin
        got_id <= irq_vec.id;
        got_lvl <= irq_vec.level;
        depth <= depth + 1;
        tmr <= HOLD;
      end else if (tmr > 1) begin
        tmr <= tmr - 1;
      end else if (depth > 0) begin
        irq_ret <= 1'b1;
        depth <= depth - 1;
        tmr <= HOLD;
      end
    end
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module testbench;
  import iep_pkg::*;
  typedef struct {
    logic [7:0] em;
    logic [7:0] ee;
    logic [7:0] rq;
    logic [4:0] v;
  } iep_row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, ack_en;
  logic ext_line_zero_pin, ext_line_one_pin, ext_line_two_pin;
  logic irq_ack, irq_ret, stop_wake;
  logic [IEP_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] got_id;
  logic [1:0] got_lvl;
  iep_periph_req_t periph_req;
  iep_vec_t irq_vec;
  int err_count, checks_done, cyc;
  iep_row_t rows [11] = '{'{8'h82, 8'h00, 8'h01, 5'h11},
    '{8'h80, 8'h00, 8'h01, 5'h00}, '{8'h7f, 8'h1f, 8'hff, 5'h00},
    '{8'h88, 8'h00, 8'h02, 5'h13}, '{8'hb0, 8'h00, 8'h0c, 5'h14},
    '{8'ha0, 8'h00, 8'h0c, 5'h15}, '{8'h80, 8'h1f, 8'hf0, 5'h16},
    '{8'h80, 8'h1e, 8'hf0, 5'h17}, '{8'h80, 8'h1c, 8'hf0, 5'h19},
    '{8'h80, 8'h10, 8'hf0, 5'h1a}, '{8'h80, 8'h0f, 8'h80, 5'h00}};
  logic [7:0] ridx [6] = '{8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hba, 8'hbb};
  logic [7:0] rmsk [6] = '{8'hbf, 8'h1f, 8'h3f, 8'h3f, 8'h1f, 8'h1f};

  iep_ctrl i_iep_ctrl (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_line_zero_pin,
    .ext_line_one_pin, .ext_line_two_pin, .periph_req, .irq_ack,
    .irq_ret, .irq_vec, .stop_wake);
  iep_core_model i_iep_core_model (.clk, .rst, .irq_vec, .ack_en,
    .irq_ack, .irq_ret, .got_id, .got_lvl);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [4:0] vsum();
    return {irq_vec.valid, irq_vec.id & {4{irq_vec.valid}}};
  endfunction

  // Ends with an idle edge so back-to-back calls never drive psel twice
  task apb_rw(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {rst, ext_line_zero_pin, ext_line_one_pin, ext_line_two_pin} = 4'hf;
    {psel, penable, pwrite, ack_en, paddr, pwdata} = '0;
    {periph_req, err_count, checks_done, cyc} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      apb_rw(1'b0, ridx[i], 8'h00);
      `CHK("reset", 32'h0, rd)
      apb_rw(1'b1, ridx[i], 8'hff);
      apb_rw(1'b0, ridx[i], 8'h00);
      `CHK("bits", {24'h0, rmsk[i]}, rd)
      apb_rw(1'b1, ridx[i], 8'h00);
    end
    apb_rw(1'b0, 8'hc0, 8'h00);
    `CHK("unmapped", 33'h100000000, {er, rd})
    foreach (rows[i]) begin
      periph_req <= '0;
      apb_rw(1'b1, 8'ha8, rows[i].em);
      apb_rw(1'b1, 8'ha9, rows[i].ee);
      periph_req <= rows[i].rq;
      repeat (3) @(posedge clk);
      `CHK("vec", rows[i].v, vsum())
    end
    periph_req <= '0;
    apb_rw(1'b1, 8'ha8, 8'h05);
    apb_rw(1'b1, 8'ha9, 8'h00);
    ext_line_zero_pin <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("wake0", 2'b10, {stop_wake, irq_vec.valid})
    ext_line_zero_pin <= 1'b1;
    ext_line_one_pin <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("wake1", 1'b1, stop_wake)
    apb_rw(1'b1, 8'ha8, 8'h81);
    @(posedge clk);
    `CHK("off1", 1'b0, stop_wake)
    ext_line_one_pin <= 1'b1;
    ext_line_zero_pin <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("line0", 5'h10, vsum())
    ext_line_zero_pin <= 1'b1;
    apb_rw(1'b1, 8'ha8, 8'h00);
    ext_line_two_pin <= 1'b0;
    repeat (8) @(posedge clk);
    apb_rw(1'b0, 8'h95, 8'h00);
    `CHK("edge", 1'b1, rd[2])
    `CHK("nowake", 1'b0, stop_wake)
    apb_rw(1'b1, 8'ha9, 8'h04);
    @(posedge clk);
    `CHK("wake2", 1'b1, stop_wake)
    apb_rw(1'b1, 8'h95, 8'hfb);
    apb_rw(1'b0, 8'h95, 8'h00);
    `CHK("clear", 1'b0, rd[2])
    `CHK("nowake2", 1'b0, stop_wake)
    apb_rw(1'b1, 8'ha9, 8'h00);
    ext_line_two_pin <= 1'b1;
    ack_en <= 1'b1;
    apb_rw(1'b1, 8'hb8, 8'h12);
    apb_rw(1'b1, 8'hb9, 8'h08);
    apb_rw(1'b1, 8'ha8, 8'h9a);
    periph_req <= 8'h01;
    repeat (6) @(posedge clk);
    `CHK("take", 6'h05, {got_id, got_lvl})
    periph_req <= 8'h05;
    repeat (6) @(posedge clk);
    `CHK("equal", 6'h05, {got_id, got_lvl})
    periph_req <= 8'h07;
    repeat (6) @(posedge clk);
    `CHK("preempt", 6'h0e, {got_id, got_lvl})
    periph_req <= '0;
    repeat (100) @(posedge clk);
    `CHK("idle", 1'b0, irq_vec.valid)
    // Both handlers must have returned, or level one stays blocked
    periph_req <= 8'h01;
    repeat (6) @(posedge clk);
    `CHK("retake", 6'h05, {got_id, got_lvl})
    periph_req <= '0;
    repeat (50) @(posedge clk);
    apb_rw(1'b1, 8'ha9, 8'h04);
    apb_rw(1'b1, 8'ha8, 8'h80);
    ext_line_two_pin <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("ack2", 6'h20, {got_id, got_lvl})
    apb_rw(1'b0, 8'h95, 8'h00);
    `CHK("autoclr", 1'b0, rd[2])
    ext_line_two_pin <= 1'b1;
    apb_rw(1'b1, 8'ha8, 8'h81);
    ext_line_zero_pin <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("pre_rst", 1'b1, stop_wake)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("rst_out", 2'b00, {stop_wake, irq_vec.valid})
    apb_rw(1'b0, 8'ha8, 8'h00);
    `CHK("rst_en", 32'h0, rd)
    apb_rw(1'b0, 8'hb8, 8'h00);
    `CHK("rst_prio", 32'h0, rd)
    finish_test();
  end
endmodule

bind iep_ctrl iep_chk i_iep_chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_line_zero_pin,
  .ext_line_one_pin, .ext_line_two_pin, .periph_req, .irq_ack,
  .irq_ret, .irq_vec, .stop_wake);

/* verilog/iep_arbiter.sv */
`timescale 1ns/1ps
module iep_arbiter
  import iep_pkg::*;
#(
  parameter int N = IEP_NSRC
) (
  // Pending requests and their levels
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0][1:0] lvl,
  // Winner
  output iep_vec_t win
);

  // Scan downward so that on a tie the lowest index wins
  always_comb begin
    win = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i] && (!win.valid || lvl[i] >= win.level)) begin
        win.valid = 1'b1;
        win.id = IEP_ID_W'(i);
        win.level = lvl[i];
      end
    end
  end

endmodule

/* verilog/iep_ctrl.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module iep_ctrl
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IEP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins, active low
  input wire logic ext_line_zero_pin,
  input wire logic ext_line_one_pin,
  input wire logic ext_line_two_pin,
  // Peripheral requests
  input iep_periph_req_t periph_req,
  // Core side
  input wire logic irq_ack,
  input wire logic irq_ret,
  output iep_vec_t irq_vec,
  output logic stop_wake
);

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [7:0] irq_enable_main_reg;
  logic [7:0] irq_enable_ext_reg;
  logic [7:0] irq_prio_low_main_reg;
  logic [7:0] irq_prio_high_main_reg;
  logic [7:0] irq_prio_low_ext_reg;
  logic [7:0] irq_prio_high_ext_reg;
  logic ext_two_edge_flag_reg;
  logic ext_two_prev_reg;
  logic [3:0] in_service_reg;
  iep_vec_t irq_vec_reg;
  logic stop_wake_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // -----------------------------------------------------------------
  // Named fields
  // -----------------------------------------------------------------
  logic global_irq_gate;
  logic ext_line_zero_en;
  logic ext_line_one_en;
  logic ext_line_two_en;
  assign global_irq_gate = irq_enable_main_reg[IEP_GLOBAL_BIT];
  assign ext_line_zero_en = irq_enable_main_reg[IEP_EXT0_BIT];
  assign ext_line_one_en = irq_enable_main_reg[IEP_EXT1_BIT];
  assign ext_line_two_en = irq_enable_ext_reg[IEP_EXT2_BIT];

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [2:0] pin_level;

  iep_pin_sync #(
    .WIDTH(3),
    .IDLE(3'h7)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({ext_line_two_pin, ext_line_one_pin, ext_line_zero_pin}),
    .level(pin_level)
  );

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  logic [7:0] idx;
  logic aligned;
  logic access;
  logic wr_en;
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[IEP_ADDR_W-1:10] == '0);
  assign access = psel && penable && pready_reg;
  assign wr_en = access && pwrite && !pslverr_reg;

  function automatic logic mapped(input logic [7:0] i);
    case (i)
      IEP_IDX_FLAG, IEP_IDX_EN_MAIN, IEP_IDX_EN_EXT,
      IEP_IDX_PLO_MAIN, IEP_IDX_PHI_MAIN,
      IEP_IDX_PLO_EXT, IEP_IDX_PHI_EXT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] i);
    hit = wr_en && (idx == i);
  endfunction

  logic [7:0] flag_view;
  assign flag_view = {5'h00, ext_two_edge_flag_reg,
                      periph_req.pin_change, periph_req.rtc_timer};

  logic [7:0] rd_mux;
  always_comb begin
    case (idx)
      IEP_IDX_FLAG: rd_mux = flag_view;
      IEP_IDX_EN_MAIN: rd_mux = irq_enable_main_reg;
      IEP_IDX_EN_EXT: rd_mux = irq_enable_ext_reg;
      IEP_IDX_PLO_MAIN: rd_mux = irq_prio_low_main_reg;
      IEP_IDX_PHI_MAIN: rd_mux = irq_prio_high_main_reg;
      IEP_IDX_PLO_EXT: rd_mux = irq_prio_low_ext_reg;
      IEP_IDX_PHI_EXT: rd_mux = irq_prio_high_ext_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // One wait state: pready rises on the second access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !(aligned && mapped(idx));
      prdata_reg <= (aligned && !pwrite) ? {24'h000000, rd_mux} : 32'h0;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // Enable and priority registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_main_reg <= IEP_RST_REG;
    end else if (hit(IEP_IDX_EN_MAIN)) begin
      irq_enable_main_reg <= pwdata[7:0] & IEP_MASK_EN_MAIN;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_ext_reg <= IEP_RST_REG;
    end else if (hit(IEP_IDX_EN_EXT)) begin
      irq_enable_ext_reg <= pwdata[7:0] & IEP_MASK_EXT5;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_prio_low_main_reg <= IEP_RST_REG;
      irq_prio_high_main_reg <= IEP_RST_REG;
    end else begin
      if (hit(IEP_IDX_PLO_MAIN)) begin
        irq_prio_low_main_reg <= pwdata[7:0] & IEP_MASK_MAIN6;
      end
      if (hit(IEP_IDX_PHI_MAIN)) begin
        irq_prio_high_main_reg <= pwdata[7:0] & IEP_MASK_MAIN6;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_prio_low_ext_reg <= IEP_RST_REG;
      irq_prio_high_ext_reg <= IEP_RST_REG;
    end else begin
      if (hit(IEP_IDX_PLO_EXT)) begin
        irq_prio_low_ext_reg <= pwdata[7:0] & IEP_MASK_EXT5;
      end
      if (hit(IEP_IDX_PHI_EXT)) begin
        irq_prio_high_ext_reg <= pwdata[7:0] & IEP_MASK_EXT5;
      end
    end
  end

  // -----------------------------------------------------------------
  // Line two edge flag
  // -----------------------------------------------------------------
  logic ext_two_fall;
  logic ack_ext2;
  logic sw_clr_ext2;
  assign ext_two_fall = ext_two_prev_reg && !pin_level[2];
  assign ack_ext2 = irq_ack && irq_vec_reg.valid &&
                    (irq_vec_reg.id == IEP_SRC_EXT2);
  assign sw_clr_ext2 = hit(IEP_IDX_FLAG) && !pwdata[IEP_FLAG_EXT2_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_two_prev_reg <= 1'b1;
    end else begin
      ext_two_prev_reg <= pin_level[2];
    end
  end

  // Set wins over clear so an edge in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_two_edge_flag_reg <= 1'b0;
    end else if (ext_two_fall) begin
      ext_two_edge_flag_reg <= 1'b1;
    end else if (ack_ext2 || sw_clr_ext2) begin
      ext_two_edge_flag_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Request gating
  // -----------------------------------------------------------------
  logic [IEP_NSRC-1:0] raw;
  logic [IEP_NSRC-1:0] enable;
  logic [IEP_NSRC-1:0] pend;
  logic [IEP_NSRC-1:0][1:0] lvl;

  // Lines zero and one request while held low
  assign raw = {periph_req.spi, periph_req.conv_touch,
                ext_two_edge_flag_reg, periph_req.pin_change,
                periph_req.rtc_timer, periph_req.timer_two,
                periph_req.uart, periph_req.timer_one,
                !pin_level[1], periph_req.timer_zero, !pin_level[0]};

  // Main enable bit i sits at source i; ext enable bit i sits at source IEP_NMAIN+i
  assign enable = {irq_enable_ext_reg[IEP_NEXT-1:0],
                   irq_enable_main_reg[IEP_NMAIN-1:0]};
  assign pend = raw & enable & {IEP_NSRC{global_irq_gate}};

  genvar s;
  generate
    for (s = 0; s < IEP_NMAIN; s++) begin : g_lvl_main
      assign lvl[s] = {irq_prio_high_main_reg[s],
                       irq_prio_low_main_reg[s]};
    end
    for (s = 0; s < IEP_NEXT; s++) begin : g_lvl_ext
      assign lvl[IEP_NMAIN+s] = {irq_prio_high_ext_reg[s],
                                 irq_prio_low_ext_reg[s]};
    end
  endgenerate

  iep_vec_t win;

  iep_arbiter #(
    .N(IEP_NSRC)
  ) u_arb (
    .pend(pend),
    .lvl(lvl),
    .win(win)
  );

  // -----------------------------------------------------------------
  // In-service tracking and preemption
  // -----------------------------------------------------------------
  logic busy;
  logic [1:0] run_level;
  always_comb begin
    busy = |in_service_reg;
    run_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_reg[l]) begin
        run_level = 2'(l);
      end
    end
  end

  // Only a strictly higher level may break into a running handler
  logic may_take;
  assign may_take = win.valid && (!busy || win.level > run_level);

  logic [3:0] top_bit;
  always_comb begin
    top_bit = 4'h0;
    top_bit[run_level] = busy;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_service_reg <= 4'h0;
    end else if (irq_ack && irq_vec_reg.valid) begin
      in_service_reg <= in_service_reg | (4'h1 << irq_vec_reg.level);
    end else if (irq_ret) begin
      in_service_reg <= in_service_reg & ~top_bit;
    end
  end

  // The request drops for one cycle after each acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_vec_reg <= '0;
    end else if (irq_ack) begin
      irq_vec_reg <= '0;
    end else if (may_take) begin
      irq_vec_reg <= win;
    end else begin
      irq_vec_reg <= '0;
    end
  end

  // -----------------------------------------------------------------
  // Stop-mode wake, independent of the global gate
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_wake_reg <= 1'b0;
    end else begin
      stop_wake_reg <= (ext_line_zero_en && !pin_level[0]) ||
                       (ext_line_one_en && !pin_level[1]) ||
                       (ext_line_two_en && ext_two_edge_flag_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_vec = irq_vec_reg;
  assign stop_wake = stop_wake_reg;

endmodule

/* verilog/iep_pin_sync.sv */
`timescale 1ns/1ps
module iep_pin_sync
  import iep_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and filtered level
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once two settled stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          level_reg[i] <= IDLE[i];
        end else if (s2_reg[i] == s3_reg[i]) begin
          level_reg[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

  assign level = level_reg;

endmodule

/* verilog/iep_pkg.sv */
package iep_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IEP_IDX_FLAG = 8'h95;
  localparam logic [7:0] IEP_IDX_EN_MAIN = 8'ha8;
  localparam logic [7:0] IEP_IDX_EN_EXT = 8'ha9;
  localparam logic [7:0] IEP_IDX_PLO_MAIN = 8'hb8;
  localparam logic [7:0] IEP_IDX_PHI_MAIN = 8'hb9;
  localparam logic [7:0] IEP_IDX_PLO_EXT = 8'hba;
  localparam logic [7:0] IEP_IDX_PHI_EXT = 8'hbb;
  localparam int IEP_ADDR_W = 12;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IEP_GLOBAL_BIT = 7;
  localparam int IEP_EXT0_BIT = 0;
  localparam int IEP_EXT1_BIT = 2;
  localparam int IEP_EXT2_BIT = 2;
  localparam int IEP_FLAG_EXT2_BIT = 2;
  localparam int IEP_FLAG_PCHG_BIT = 1;
  localparam int IEP_FLAG_RTC_BIT = 0;

  // ---------------------------------------------------------------
  // Writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IEP_MASK_EN_MAIN = 8'hbf;
  localparam logic [7:0] IEP_MASK_MAIN6 = 8'h3f;
  localparam logic [7:0] IEP_MASK_EXT5 = 8'h1f;
  localparam logic [7:0] IEP_RST_REG = 8'h00;

  // ---------------------------------------------------------------
  // Sources, in fixed polling order
  // ---------------------------------------------------------------
  localparam int IEP_NSRC = 11;
  localparam int IEP_NMAIN = 6;
  localparam int IEP_NEXT = 5;
  localparam int IEP_ID_W = 4;
  localparam logic [IEP_ID_W-1:0] IEP_SRC_EXT2 = 4'h8;

  // Peripheral request levels, active high
  typedef struct packed {
    logic spi;
    logic conv_touch;
    logic pin_change;
    logic rtc_timer;
    logic timer_two;
    logic uart;
    logic timer_one;
    logic timer_zero;
  } iep_periph_req_t;

  // Vector request toward the core
  typedef struct packed {
    logic valid;
    logic [IEP_ID_W-1:0] id;
    logic [1:0] level;
  } iep_vec_t;

endpackage
